/* File: src/bri_pkg.sv */
// Constants for the boot record initialization sequencer.
// Assumes a 32-bit external read/write port with a ready handshake and APB registers.
package bri_pkg;
    // Boot record and table addresses
    localparam logic [31:0] BOOT_REC_BASE = 32'hFEFFFF30;
    localparam logic [31:0] BOOT_FETCH_START = 32'hFEFFFF38;
    localparam logic [31:0] FAIL_CODE_ADDR = 32'hFEFFFF64;
    localparam logic [31:0] NMI_RAM_ADDR = 32'h00000000;
    localparam logic [7:0] OFS_CFG_BYTE2 = 8'h08;
    localparam logic [7:0] OFS_CFG_BYTE3 = 8'h0C;
    localparam logic [7:0] OFS_FIRST_IP = 8'h10;
    localparam logic [7:0] OFS_CTRL_BLOCK = 8'h14;
    localparam logic [7:0] OFS_CHECK_FIRST = 8'h10;
    localparam logic [3:0] CHECK_WORDS = 4'h8;
    localparam logic [7:0] CB_INT_TABLE = 8'h10;
    localparam logic [7:0] CB_SYSPROC = 8'h14;
    localparam logic [7:0] CB_INT_STACK = 8'h1C;
    localparam logic [7:0] SYSPROC_SSP = 8'h0C;
    localparam logic [11:0] NMI_ENTRY_OFS = 12'h3E4;
    localparam logic [31:0] CHECK_SEED = 32'hFFFFFFFF;
    localparam logic [31:0] BYTE2_MASK = 32'h00C00000;
    localparam logic [31:0] ALIGN16_MASK = 32'hFFFFFFF0;
    // Process controls: priority 31, supervisor, trace off, interrupted
    localparam logic [31:0] PROC_CTRL_INIT = 32'h001F2002;
    localparam logic [7:0] BUS_WIDTH_8BIT = 8'h00;
    localparam logic [3:0] SELF_TEST_CYCLES = 4'hF;
    // APB register byte addresses
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_BUS_CFG = 8'h04;
    localparam logic [7:0] REG_SSP = 8'h08;
    localparam logic [7:0] REG_ISP = 8'h0C;
    localparam logic [7:0] REG_FP = 8'h10;
    localparam logic [7:0] REG_IP = 8'h14;
    localparam logic [7:0] REG_NMI = 8'h18;
    localparam logic [7:0] REG_PCTRL = 8'h1C;
    localparam logic [7:0] REG_SELFTEST = 8'h20;
    // Sequencer states, one-hot
    typedef enum logic [11:0] {
        ST_RESET = 12'h001,
        ST_SELFTEST = 12'h002,
        ST_CFG = 12'h004,
        ST_SUM = 12'h008,
        ST_FAILRD = 12'h010,
        ST_HALT = 12'h020,
        ST_CB = 12'h040,
        ST_INTTAB = 12'h080,
        ST_NMI = 12'h100,
        ST_SYSPROC = 12'h200,
        ST_STACKS = 12'h400,
        ST_RUN = 12'h800
    } bri_state_e;
endpackage : bri_pkg

/* File: src/bri_sum_acc.sv */
// End-around-carry accumulator for the bus confidence checksum.
// Assumes the sequencer pulses clear before the first word.
`timescale 1ns/1ns
module bri_sum_acc (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clear,
    input wire logic add_en,
    input wire logic [31:0] word,
    output logic [31:0] sum_q,
    output logic zero
);
    logic carry_q;
    logic [32:0] add_w;

    // Previous carry-out folds back into the next add
    assign add_w = {1'b0, sum_q} + {1'b0, word} + {32'h0, carry_q};
    assign zero = (sum_q == 32'h0);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sum_q <= 32'hFFFFFFFF;
            carry_q <= 1'b0;
        end
        else if (clear)
        begin
            sum_q <= bri_pkg::CHECK_SEED;
            carry_q <= 1'b0;
        end
        else if (add_en)
        begin
            sum_q <= add_w[31:0];
            carry_q <= add_w[32];
        end
    end
endmodule : bri_sum_acc

/* File: src/bri_boot_seq.sv */
// Boot record initialization sequencer: fetches the boot record, checks the
// bus, loads stack pointers and NMI vector. Assumes a read/write memory port
// with one-cycle request strobe and a ready answer, and an APB master.
`timescale 1ns/1ns
module bri_boot_seq (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic self_test_select,
    input wire logic [31:0] dev_id,
    // External memory port
    output logic mem_req,
    output logic mem_we,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    input wire logic [31:0] mem_rdata,
    input wire logic mem_ready,
    output logic [31:0] boot_region_bus_config,
    output logic bus_table_valid_bit,
    output logic fail_n,
    output logic running,
    output logic [31:0] q0,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    bri_pkg::bri_state_e state_q;
    logic st_sync1_q, st_sync2_q;
    logic [3:0] step_q, built_in_self_test_cnt_q;
    logic busy_q, done;
    logic [31:0] ctrl_block_q, first_ip_q, int_table_q, sysproc_q;
    logic [31:0] supervisor_stack_pointer, interrupt_stack_pointer, frame_pointer;
    logic [31:0] instruction_pointer, nmi_vector_q, process_controls;
    logic default_byte_order_bit, default_data_cache_enable;
    logic [7:0] cfg_byte2_q;
    logic icache_en_q, interrupt_mask_q, local_translation_enable, built_in_self_test_fail_inject_q;
    logic sum_clear, sum_add, sum_zero;
    logic [31:0] sum_val;
    logic apb_wr, apb_rd;

    assign done = busy_q && mem_ready;
    assign sum_clear = (state_q == bri_pkg::ST_CFG) && done && step_q == 4'h1;
    assign sum_add = (state_q == bri_pkg::ST_SUM) && done;
    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && !penable && !pwrite;

    bri_sum_acc u_sum (
        .pclk(pclk),
        .presetn(presetn),
        .clear(sum_clear),
        .add_en(sum_add),
        .word(mem_rdata),
        .sum_q(sum_val),
        .zero(sum_zero)
    );

    // Self-test select is a pin: two flops before use
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_sync1_q <= 1'b0;
            st_sync2_q <= 1'b0;
        end
        else
        begin
            st_sync1_q <= self_test_select;
            st_sync2_q <= st_sync1_q;
        end
    end

    // Issue one memory access; busy_q stays set until ready
    task automatic issue(input logic [31:0] a, input logic w, input logic [31:0] d);
        mem_req <= 1'b1;
        mem_addr <= a;
        mem_we <= w;
        mem_wdata <= d;
        busy_q <= 1'b1;
    endtask : issue

    // Main sequencer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= bri_pkg::ST_RESET;
            step_q <= 4'h0;
            built_in_self_test_cnt_q <= 4'h0;
            busy_q <= 1'b0;
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_addr <= 32'h0;
            mem_wdata <= 32'h0;
            fail_n <= 1'b0;
            running <= 1'b0;
            q0 <= 32'h0;
            boot_region_bus_config <= 32'h0;
            bus_table_valid_bit <= 1'b0;
            default_byte_order_bit <= 1'b0;
            default_data_cache_enable <= 1'b0;
            cfg_byte2_q <= 8'h00;
            icache_en_q <= 1'b0;
            interrupt_mask_q <= 1'b0;
            local_translation_enable <= 1'b0;
            process_controls <= 32'h0;
            ctrl_block_q <= 32'h0;
            first_ip_q <= 32'h0;
            int_table_q <= 32'h0;
            sysproc_q <= 32'h0;
            supervisor_stack_pointer <= 32'h0;
            interrupt_stack_pointer <= 32'h0;
            frame_pointer <= 32'h0;
            instruction_pointer <= 32'h0;
            nmi_vector_q <= 32'h0;
        end
        else
        begin
            mem_req <= 1'b0;
            if (done)
                busy_q <= 1'b0;
            unique case (state_q)
                bri_pkg::ST_RESET:
                begin
                    // Caches off, mask and translation cleared, 8-bit boot region
                    fail_n <= 1'b0;
                    icache_en_q <= 1'b0;
                    default_data_cache_enable <= 1'b0;
                    interrupt_mask_q <= 1'b0;
                    local_translation_enable <= 1'b0;
                    bus_table_valid_bit <= 1'b0;
                    boot_region_bus_config <= {24'h0, bri_pkg::BUS_WIDTH_8BIT};
                    built_in_self_test_cnt_q <= bri_pkg::SELF_TEST_CYCLES;
                    // Select pin needs two edges through its synchroniser before it is valid
                    step_q <= (step_q == 4'h2) ? 4'h0 : step_q + 4'h1;
                    if (step_q == 4'h2)
                        state_q <= st_sync2_q ? bri_pkg::ST_SELFTEST : bri_pkg::ST_CFG;
                    if (!st_sync2_q && step_q == 4'h2)
                    begin
                        fail_n <= 1'b1;
                        process_controls <= bri_pkg::PROC_CTRL_INIT;
                    end
                end
                bri_pkg::ST_SELFTEST:
                begin
                    // A failing self test stays here until reset or a REG_SELFTEST write clears the injection bit
                    if (built_in_self_test_cnt_q != 4'h0)
                        built_in_self_test_cnt_q <= built_in_self_test_cnt_q - 4'h1;
                    else if (!built_in_self_test_fail_inject_q)
                    begin
                        fail_n <= 1'b1;
                        process_controls <= bri_pkg::PROC_CTRL_INIT;
                        state_q <= bri_pkg::ST_CFG;
                    end
                end
                bri_pkg::ST_CFG:
                begin
                    // Fetch words at offsets 8 and 12; offsets 0 and 4 are skipped
                    if (!busy_q && step_q == 4'h0)
                    begin
                        fail_n <= 1'b0;
                        issue(bri_pkg::BOOT_FETCH_START, 1'b0, 32'h0);
                    end
                    else if (done && step_q == 4'h0)
                    begin
                        cfg_byte2_q <= mem_rdata[7:0] & bri_pkg::BYTE2_MASK[23:16];
                        step_q <= 4'h1;
                    end
                    else if (!busy_q && step_q == 4'h1)
                        issue(bri_pkg::BOOT_REC_BASE + 32'(bri_pkg::OFS_CFG_BYTE3), 1'b0, 32'h0);
                    else if (done)
                    begin
                        default_byte_order_bit <= mem_rdata[7];
                        default_data_cache_enable <= 1'b0;
                        boot_region_bus_config <= {1'b0, mem_rdata[6:0], cfg_byte2_q,
                            16'h0};
                        step_q <= 4'h0;
                        state_q <= bri_pkg::ST_SUM;
                    end
                end
                bri_pkg::ST_SUM:
                begin
                    // Eight words from offset 16; keep IP and control block words
                    if (!busy_q && step_q != bri_pkg::CHECK_WORDS)
                        issue(bri_pkg::BOOT_REC_BASE + 32'(bri_pkg::OFS_CHECK_FIRST)
                            + {26'h0, step_q, 2'b00}, 1'b0, 32'h0);
                    else if (done)
                    begin
                        if (step_q == 4'h0)
                            first_ip_q <= mem_rdata;
                        if (step_q == 4'h1)
                            ctrl_block_q <= mem_rdata;
                        step_q <= step_q + 4'h1;
                    end
                    else if (!busy_q)
                    begin
                        step_q <= 4'h0;
                        state_q <= sum_zero ? bri_pkg::ST_CB : bri_pkg::ST_FAILRD;
                        fail_n <= sum_zero;
                    end
                end
                bri_pkg::ST_FAILRD:
                begin
                    // Exactly one fail-code read, then halt
                    if (!busy_q)
                        issue(bri_pkg::FAIL_CODE_ADDR, 1'b0, 32'h0);
                    state_q <= bri_pkg::ST_HALT;
                end
                bri_pkg::ST_HALT:
                    fail_n <= 1'b0;
                bri_pkg::ST_CB:
                begin
                    // Control block: interrupt table, system procedures, stack
                    if (!busy_q && step_q == 4'h0)
                        issue(ctrl_block_q + 32'(bri_pkg::CB_INT_TABLE), 1'b0, 32'h0);
                    else if (done && step_q == 4'h0)
                    begin
                        int_table_q <= mem_rdata;
                        step_q <= 4'h1;
                    end
                    else if (!busy_q && step_q == 4'h1)
                        issue(ctrl_block_q + 32'(bri_pkg::CB_SYSPROC), 1'b0, 32'h0);
                    else if (done && step_q == 4'h1)
                    begin
                        sysproc_q <= mem_rdata;
                        step_q <= 4'h2;
                    end
                    else if (!busy_q && step_q == 4'h2)
                        issue(ctrl_block_q + 32'(bri_pkg::CB_INT_STACK), 1'b0, 32'h0);
                    else if (done)
                    begin
                        interrupt_stack_pointer <= mem_rdata;
                        frame_pointer <= mem_rdata & bri_pkg::ALIGN16_MASK;
                        step_q <= 4'h0;
                        state_q <= bri_pkg::ST_INTTAB;
                    end
                end
                bri_pkg::ST_INTTAB:
                begin
                    if (!busy_q)
                        issue(int_table_q + 32'(bri_pkg::NMI_ENTRY_OFS), 1'b0, 32'h0);
                    else if (done)
                    begin
                        nmi_vector_q <= mem_rdata;
                        state_q <= bri_pkg::ST_NMI;
                    end
                end
                bri_pkg::ST_NMI:
                begin
                    if (!busy_q)
                        issue(bri_pkg::NMI_RAM_ADDR, 1'b1, nmi_vector_q);
                    else if (done)
                        state_q <= bri_pkg::ST_SYSPROC;
                end
                bri_pkg::ST_SYSPROC:
                begin
                    if (!busy_q)
                        issue(sysproc_q + 32'(bri_pkg::SYSPROC_SSP), 1'b0, 32'h0);
                    else if (done)
                    begin
                        supervisor_stack_pointer <= mem_rdata & bri_pkg::ALIGN16_MASK;
                        state_q <= bri_pkg::ST_STACKS;
                    end
                end
                bri_pkg::ST_STACKS:
                begin
                    // Region table assumed loaded; set the bus table valid bit
                    bus_table_valid_bit <= 1'b1;
                    instruction_pointer <= first_ip_q;
                    q0 <= dev_id;
                    state_q <= bri_pkg::ST_RUN;
                end
                bri_pkg::ST_RUN:
                    running <= 1'b1;
            endcase
        end
    end

    // Self-test failure injection, written by software for test purposes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            built_in_self_test_fail_inject_q <= 1'b0;
        else if (apb_wr && paddr == bri_pkg::REG_SELFTEST)
            built_in_self_test_fail_inject_q <= pwdata[0];
    end

    // APB read data, zero-wait; unmapped reads return zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0;
        else if (apb_rd)
            unique case (paddr)
                bri_pkg::REG_STATUS: prdata <= {16'h0, state_q[11:0], running,
                    bus_table_valid_bit, default_byte_order_bit, fail_n};
                bri_pkg::REG_BUS_CFG: prdata <= boot_region_bus_config;
                bri_pkg::REG_SSP: prdata <= supervisor_stack_pointer;
                bri_pkg::REG_ISP: prdata <= interrupt_stack_pointer;
                bri_pkg::REG_FP: prdata <= frame_pointer;
                bri_pkg::REG_IP: prdata <= instruction_pointer;
                bri_pkg::REG_NMI: prdata <= nmi_vector_q;
                bri_pkg::REG_PCTRL: prdata <= process_controls;
                bri_pkg::REG_SELFTEST: prdata <= {31'h0, built_in_self_test_fail_inject_q};
                default: prdata <= 32'h0;
            endcase
    end

    // Ready in the access phase of every transfer; slave errors never raised
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
            pready <= psel && !penable;
    end

    chk_fp_align: assert property (@(posedge pclk) disable iff (!presetn)
        frame_pointer[3:0] == 4'h0) else $error("frame pointer not aligned");
    chk_ssp_align: assert property (@(posedge pclk) disable iff (!presetn)
        supervisor_stack_pointer[3:0] == 4'h0) else $error("ssp not aligned");
    chk_fail_halt: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == bri_pkg::ST_HALT |=> state_q == bri_pkg::ST_HALT && !fail_n)
        else $error("halt left");
    chk_run_fail: assert property (@(posedge pclk) disable iff (!presetn)
        running |-> fail_n && bus_table_valid_bit) else $error("run with fail");
    chk_ctv_cfg: assert property (@(posedge pclk) disable iff (!presetn)
        mem_req |-> !bus_table_valid_bit) else $error("request after table valid");
    chk_first_fetch: assert property (@(posedge pclk) disable iff (!presetn)
        mem_req && state_q == bri_pkg::ST_CFG && step_q == 4'h0
        |-> mem_addr == bri_pkg::BOOT_FETCH_START) else $error("bad first fetch");
    chk_pctrl_init: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == bri_pkg::ST_SUM |-> process_controls == bri_pkg::PROC_CTRL_INIT)
        else $error("process controls wrong");
    chk_dcache_off: assert property (@(posedge pclk) disable iff (!presetn)
        !default_data_cache_enable) else $error("data cache enabled");
    chk_failrd_once: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == bri_pkg::ST_FAILRD |=> mem_req && mem_addr == bri_pkg::FAIL_CODE_ADDR
        ##1 !mem_req[*3]) else $error("fail read count");
endmodule : bri_boot_seq

/* File: verification/bri_rom_model.sv */
// Boot ROM model on the external memory port of the sequencer.
// Assumes a one-cycle request strobe with address held until ready.
`timescale 1ns/1ns
module bri_rom_model (
    input wire logic pclk,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    input wire logic [3:0] wait_cycles,
    output logic [31:0] mem_rdata,
    output logic mem_ready
);
    logic [31:0] mem [logic [31:0]];
    logic [31:0] log_q [$];
    int cnt = -1;
    initial mem_ready = 1'b0;
    initial mem_rdata = 32'h00000000;
    // Answer after the set wait; the data line toggles when idle so stale data never matches
    always @(posedge pclk)
    begin
        mem_ready <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (mem_req)
        begin
            log_q.push_back(mem_addr);
            cnt = wait_cycles;
        end
        else if (cnt > 0)
            cnt = cnt - 1;
        if (cnt == 0)
        begin
            cnt = -1;
            mem_ready <= 1'b1;
            if (mem_we)
                mem[mem_addr] = mem_wdata;
            else
                mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : ~mem_addr;
        end
    end
endmodule : bri_rom_model

/* File: verification/boot_record_init_sequencer_tb_top.sv */
// Self-checking bench: boot passes, checksum failure, self-test hang.
// Assumes the boot ROM model answers the sequencer's memory port.
`timescale 1ns/1ns
module boot_record_init_sequencer_tb_top;
    logic pclk, presetn, self_test_select, psel, penable, pwrite;
    logic mem_req, mem_we, mem_ready, fail_n, running, bus_table_valid_bit, pready;
    logic [3:0] wait_cycles;
    logic [7:0] paddr;
    logic [31:0] dev_id, pwdata, prdata, mem_addr, mem_wdata, mem_rdata, q0, boot_region_bus_config;
    logic [31:0] rd, exp_q [$];
    int fails = 0;
    int check_count = 0;
    bri_boot_seq dut_u (.pclk(pclk), .presetn(presetn), .self_test_select(self_test_select),
        .dev_id(dev_id), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ready(mem_ready),
        .boot_region_bus_config(boot_region_bus_config),
        .bus_table_valid_bit(bus_table_valid_bit), .fail_n(fail_n), .running(running),
        .q0(q0), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr());
    bri_rom_model rom_u (.pclk(pclk), .mem_req(mem_req), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .wait_cycles(wait_cycles),
        .mem_rdata(mem_rdata), .mem_ready(mem_ready));
    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : close_out
    // One APB transfer; request held until pready is sampled high, then one idle edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // Only the watchdog ends a wait for the answer
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    // Boot image; a bad image breaks the checksum by one
    task automatic load(input logic bad);
        logic [31:0] s;
        logic [32:0] t;
        logic c;
        s = 32'hFFFFFFFF;
        c = 1'b0;
        rom_u.mem[32'hFEFFFF38] = 32'h000000FF;
        rom_u.mem[32'hFEFFFF3C] = 32'h00000085;
        rom_u.mem[32'hFEFFFF40] = 32'h00010000;
        rom_u.mem[32'hFEFFFF44] = 32'h00001000;
        for (int i = 0; i < 5; i++)
            rom_u.mem[32'hFEFFFF48 + 4 * i] = 32'h11111111 * (i + 1);
        for (int i = 0; i < 7; i++)
        begin
            t = {1'b0, rom_u.mem[32'hFEFFFF40 + 4 * i]} + {1'b0, s} + {32'h0, c};
            s = t[31:0];
            c = t[32];
        end
        rom_u.mem[32'hFEFFFF5C] = 32'h0 - s - {31'h0, c} + {31'h0, bad};
        rom_u.mem[32'h00001010] = 32'h00002000;
        rom_u.mem[32'h00001014] = 32'h00003000;
        rom_u.mem[32'h0000101C] = 32'h00004000;
        rom_u.mem[32'h000023E4] = 32'hA5A50001;
        rom_u.mem[32'h0000300C] = 32'h00005007;
    endtask : load
    task automatic start(input logic st, input logic [3:0] w, input logic bad);
        presetn <= 1'b0;
        self_test_select <= st;
        wait_cycles <= w;
        rom_u.log_q.delete();
        load(bad);
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask : start
    task automatic check_log;
        check("access count", rom_u.log_q.size(), exp_q.size());
        foreach (exp_q[i])
            check("access address", rom_u.log_q[i], exp_q[i]);
    endtask : check_log
    initial
    begin
        #(40 * 20000);
        fails++;
        close_out();
    end
    initial
    begin
        {presetn, self_test_select, psel, penable, pwrite} = 5'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        dev_id = 32'h0000C0DE; // Arbitrary identifier
        wait_cycles = 4'h2;
        // Full boot with self test and a slow ROM
        start(1'b1, 4'h2, 1'b0);
        while (mem_req !== 1'b1) @(posedge pclk);
        check("cfg before fetch", boot_region_bus_config, 32'h00000000);
        check("table valid early", {31'h0, bus_table_valid_bit}, 32'h0);
        check("fail during fetch", {31'h0, fail_n}, 32'h0);
        for (int n = 0; n < 2000 && running !== 1'b1; n++) @(posedge pclk);
        exp_q = {32'hFEFFFF38, 32'hFEFFFF3C};
        for (int i = 0; i < 8; i++)
            exp_q.push_back(32'hFEFFFF40 + 4 * i);
        exp_q = {exp_q, 32'h00001010, 32'h00001014, 32'h0000101C, 32'h000023E4, 32'h0, 32'h0000300C};
        check_log();
        check("fail pin", {31'h0, fail_n}, 32'h1);
        check("q0", q0, 32'h0000C0DE);
        check("table valid", {31'h0, bus_table_valid_bit}, 32'h1);
        check("bus cfg", boot_region_bus_config, 32'h05C00000);
        check("nmi copy", rom_u.mem[32'h0], 32'hA5A50001);
        apb(1'b0, bri_pkg::REG_SSP, 32'h0);
        check("ssp", rd, 32'h00005000);
        apb(1'b0, bri_pkg::REG_FP, 32'h0);
        check("fp", rd, 32'h00004000);
        apb(1'b0, bri_pkg::REG_IP, 32'h0);
        check("ip", rd, 32'h00010000);
        apb(1'b0, bri_pkg::REG_PCTRL, 32'h0);
        check("proc ctrl", rd, 32'h001F2002);
        apb(1'b0, bri_pkg::REG_STATUS, 32'h0);
        check("byte order", {31'h0, rd[1]}, 32'h1);
        apb(1'b0, 8'h30, 32'h0);
        check("unmapped", rd, 32'h00000000);
        $display("test boot pass done");
        // Checksum failure with a prompt ROM, self test skipped
        start(1'b0, 4'h0, 1'b1);
        repeat (300) @(posedge pclk);
        exp_q = exp_q[0:9];
        exp_q.push_back(bri_pkg::FAIL_CODE_ADDR);
        check_log();
        check("fail held", {30'h0, fail_n, running}, 32'h0);
        $display("test checksum fail done");
        // Self test made to fail: no fetch ever starts
        start(1'b1, 4'h0, 1'b0);
        apb(1'b1, bri_pkg::REG_SELFTEST, 32'h00000001);
        repeat (300) @(posedge pclk);
        check("fetches after hang", rom_u.log_q.size(), 32'h0);
        check("fail after hang", {31'h0, fail_n}, 32'h0);
        $display("test self test hang done");
        close_out();
    end
endmodule : boot_record_init_sequencer_tb_top
